/* File: logic/tcc_params.svh */
// register map, field positions and timing counts for the timer capture controller
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
// device registers, channel 0 and channel 1
`define TCC_TMC_ADDR0 16'hFF60
`define TCC_TMC_ADDR1 16'hFF68
`define TCC_PRM_ADDR0 16'hFF61
`define TCC_PRM_ADDR1 16'hFF61
`define TCC_CRC_ADDR0 16'hFF62
`define TCC_CRC_ADDR1 16'hFF6A
`define TCC_TOC_ADDR0 16'hFF63
`define TCC_TOC_ADDR1 16'hFF6B
`define TCC_CFG_RESET 8'h00
// writable bits of each device register
`define TCC_PRM_MASK 8'hF3
`define TCC_CRC_MASK 8'h07
`define TCC_TOC_MASK 8'h1F
`define TCC_TMC_MASK 8'h0E
`define TCC_OVF_MASK 8'h01
// device field positions
`define TCC_TMC_OVF 0
`define TCC_PRM_CLK_LSB 0
`define TCC_PRM_ES0_LSB 4
`define TCC_PRM_ES1_LSB 6
`define TCC_CRC_CAP1 0
`define TCC_CRC_TRIG 1
`define TCC_CRC_CAP2 2
`define TCC_TOC_GATE 0
`define TCC_TOC_RST 2
`define TCC_TOC_SET 3
// host apb map
`define TCC_A_CMD 8'h00
`define TCC_A_STAT 8'h04
`define TCC_A_PULSE 8'h08
`define TCC_CMD_GO 0
`define TCC_CMD_CH 1
`define TCC_CMD_TGT_LSB 2
`define TCC_CMD_VAL_LSB 8
`define TCC_STAT_ERR 1
// clock rates in khz; fx period rounded up to whole system cycles
`define TCC_SYS_KHZ 250000
`define TCC_FX_KHZ 12000
`define TCC_FX_CYC ((`TCC_SYS_KHZ + `TCC_FX_KHZ - 1) / `TCC_FX_KHZ)
`endif

/* File: logic/tcc_pkg.sv */
// types for the timer capture controller
`default_nettype none
package tcc_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RD, S_WAIT, S_STOP, S_WR, S_REST} tcc_seq_t;
   typedef enum logic [1:0] {T_PRM, T_CRC, T_TOC, T_TMC} tcc_tgt_t;
   typedef enum logic [1:0] {P_IDLE, P_HIGH, P_LOW} tcc_phase_t;
   typedef struct packed {
      tcc_phase_t phase;
      logic [11:0] cnt;
      logic pin;
   } tcc_pulse_st_t;
   typedef struct packed {
      tcc_seq_t seq;
      logic ch;
      tcc_tgt_t tgt;
      logic [7:0] val;
      logic [7:0] saved;
      logic [15:0] dev_addr;
      logic [7:0] dev_wdata;
      logic dev_wr;
      logic dev_rd;
      logic err;
      logic [1:0] ovf;
      logic [1:0][7:0] prm;
      logic [1:0][7:0] crc;
      logic [1:0][7:0] toc;
      logic [1:0][2:0] mode;
      logic [3:0] pulse_go;
      logic [31:0] prdata;
      logic pslverr;
   } tcc_host_st_t;
endpackage : tcc_pkg
`default_nettype wire

/* File: logic/tcc_pulse.sv */
// pulse driver for one timer input pin, high and low phases of a minimum width
`include "tcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [11:0] width_i,
   output logic pin_o,
   output logic busy_o
);
   tcc_pkg::tcc_pulse_st_t st;
   tcc_pkg::tcc_pulse_st_t next_st;
   logic [11:0] hi_len;
   logic [11:0] wlat;

   always_comb begin
      next_st = st;
      case (st.phase)
         tcc_pkg::P_IDLE: begin
            if (start_i) begin
               next_st.phase = tcc_pkg::P_HIGH;
               next_st.pin = 1'b1;
               next_st.cnt = width_i;
            end
         end
         tcc_pkg::P_HIGH: begin
            // both edges must stay apart, so the low gap is as long as the pulse
            if (st.cnt <= 12'h001) begin
               next_st.phase = tcc_pkg::P_LOW;
               next_st.pin = 1'b0;
               next_st.cnt = width_i;
            end else begin
               next_st.cnt = st.cnt - 12'h001;
            end
         end
         tcc_pkg::P_LOW: begin
            if (st.cnt <= 12'h001) begin
               next_st.phase = tcc_pkg::P_IDLE;
            end else begin
               next_st.cnt = st.cnt - 12'h001;
            end
         end
         default: begin
            next_st.phase = tcc_pkg::P_IDLE;
            next_st.pin = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pin_o = st.pin;
   assign busy_o = st.phase != tcc_pkg::P_IDLE;

   // helper for the width check below
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hi_len <= 12'h000;
         wlat <= 12'h000;
      end else begin
         hi_len <= st.pin ? hi_len + 12'h001 : 12'h000;
         if (start_i && st.phase == tcc_pkg::P_IDLE) begin
            wlat <= width_i;
         end
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_min_high;
      $fell(pin_o) |-> hi_len >= wlat && hi_len > 12'h000;
   endproperty
   a_min_high: assert property (p_min_high) // [RULE7] [RULE17]
      else $error("input pulse too short");

   property p_gap_after;
      $fell(pin_o) |-> busy_o [*2];
   endproperty
   a_gap_after: assert property (p_gap_after) else $error("no low gap after pulse"); // [RULE7]
endmodule : tcc_pulse
`default_nettype wire

/* File: logic/tcc_host.sv */
// host controller that programs the timer channels and drives their input pins
//
// Overview of operation
// (RULE1) first register: compare at 0, capture at 1
// (RULE2) second register: compare at 0, capture at 1
// (RULE3) trigger select picks second input or inverted first
// (RULE4) stop the timer before control register writes
// (RULE5) no first-register capture in clear-on-match mode
// (RULE6) both-edge first input gives no first capture
// (RULE7) capture pulses exceed two count clock periods
// (RULE8) second match toggles output when enabled
// (RULE9) first match toggles output when enabled
// (RULE10) set/reset pair: hold, clear, set; never both
// (RULE11) set and reset bits read back zero
// (RULE12) gate off holds output pin low
// (RULE13) write zero to output control bits 5-7
// (RULE14) second input edge field: never write 10
// (RULE15) first input edge field: never write 10
// (RULE16) count clock: fx, fx/4, fx/32, input edge
// (RULE17) external count pulses exceed two fx/16 periods
// (RULE18) external clock input: no clear, capture, output
// (RULE19) high input after reset gives immediate edge
// (RULE20) wrap with compare FFFF sets overflow
// (RULE21) mode bits written only while timer stopped
// (RULE22) compare registers match continuously, raising requests
// (RULE23) counter counts up, clears on stop or reset
// (RULE24) reset clears all control and output state
`include "tcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_host (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic [15:0] dev_addr_o,
   output logic [7:0] dev_wdata_o,
   output logic dev_wr_o,
   output logic dev_rd_o,
   input wire logic [7:0] dev_rdata_i,
   input wire logic [1:0] timer_output_pin_i,
   output logic [1:0] first_timer_input_o,
   output logic [1:0] second_timer_input_o
);
   tcc_pkg::tcc_host_st_t st;
   tcc_pkg::tcc_host_st_t next_st;
   logic [3:0] pin_w;
   logic [3:0] pulse_busy;
   logic busy;

   function automatic logic [15:0] addr_of(input tcc_pkg::tcc_tgt_t t, input logic c);
      logic [15:0] a;
      a = c ? `TCC_TMC_ADDR1 : `TCC_TMC_ADDR0;
      case (t)
         tcc_pkg::T_PRM: a = c ? `TCC_PRM_ADDR1 : `TCC_PRM_ADDR0;
         tcc_pkg::T_CRC: a = c ? `TCC_CRC_ADDR1 : `TCC_CRC_ADDR0;
         tcc_pkg::T_TOC: a = c ? `TCC_TOC_ADDR1 : `TCC_TOC_ADDR0;
         default: a = c ? `TCC_TMC_ADDR1 : `TCC_TMC_ADDR0;
      endcase
      return a;
   endfunction : addr_of

   function automatic logic [7:0] mask_of(input tcc_pkg::tcc_tgt_t t);
      logic [7:0] m;
      m = `TCC_TMC_MASK;
      case (t)
         tcc_pkg::T_PRM: m = `TCC_PRM_MASK;
         tcc_pkg::T_CRC: m = `TCC_CRC_MASK;
         tcc_pkg::T_TOC: m = `TCC_TOC_MASK; // [RULE13]
         default: m = `TCC_TMC_MASK;
      endcase
      return m;
   endfunction : mask_of

   // a capture register that listens to the first input
   function automatic logic ti_trig(input logic [7:0] c);
      return (c[`TCC_CRC_CAP1] && c[`TCC_CRC_TRIG]) || c[`TCC_CRC_CAP2];
   endfunction : ti_trig

   // checks a new value against the shadow copies of the same channel
   function automatic logic cfg_ok(input tcc_pkg::tcc_tgt_t t, input logic [7:0] v,
         input logic [7:0] prm, input logic [7:0] crc, input logic [7:0] toc,
         input logic [2:0] mode);
      logic ext;
      logic bad;
      ext = prm[`TCC_PRM_CLK_LSB +: 2] == 2'b11;
      bad = 1'b0;
      case (t)
         tcc_pkg::T_PRM: begin
            bad = v[`TCC_PRM_ES1_LSB +: 2] == 2'b10 // [RULE14]
               || v[`TCC_PRM_ES0_LSB +: 2] == 2'b10 // [RULE15]
               || (v[`TCC_PRM_CLK_LSB +: 2] == 2'b11
               && (mode[2:1] == 2'b10 || ti_trig(crc) || toc[`TCC_TOC_GATE])); // [RULE18]
         end
         tcc_pkg::T_CRC: begin
            bad = (v[`TCC_CRC_CAP1] && mode[2:1] == 2'b11) // [RULE5]
               || (ext && ti_trig(v)); // [RULE18]
         end
         tcc_pkg::T_TOC: begin
            bad = (v[`TCC_TOC_SET] && v[`TCC_TOC_RST]) // [RULE10]
               || (ext && v[`TCC_TOC_GATE]); // [RULE18]
         end
         default: begin
            bad = (v[3:2] == 2'b11 && crc[`TCC_CRC_CAP1]) // [RULE5]
               || (ext && v[3:2] == 2'b10); // [RULE18]
         end
      endcase
      return !bad;
   endfunction : cfg_ok

   // minimum pulse width in system cycles for a count clock selection
   function automatic logic [11:0] pulse_width(input logic [1:0] sel);
      logic [11:0] w;
      w = 12'(`TCC_FX_CYC);
      case (sel)
         2'b00: w = w << 1; // [RULE7]
         2'b01: w = w << 3; // [RULE7]
         2'b10: w = w << 6; // [RULE7]
         default: w = w << 5; // [RULE17]
      endcase
      return w + 12'h001;
   endfunction : pulse_width

   assign busy = st.seq != tcc_pkg::S_IDLE;

   always_comb begin
      logic wr_acc;
      logic go;
      logic clr_err;
      logic set_err;
      logic c;
      logic [7:0] v;
      tcc_pkg::tcc_tgt_t t;
      next_st = st;
      wr_acc = psel_i && penable_i && pwrite_i;
      go = wr_acc && paddr_i == `TCC_A_CMD && pwdata_i[`TCC_CMD_GO];
      clr_err = wr_acc && paddr_i == `TCC_A_STAT && pwdata_i[`TCC_STAT_ERR];
      c = pwdata_i[`TCC_CMD_CH];
      t = tcc_pkg::tcc_tgt_t'(pwdata_i[`TCC_CMD_TGT_LSB +: 2]);
      v = pwdata_i[`TCC_CMD_VAL_LSB +: 8] & mask_of(t); // [RULE13]
      set_err = 1'b0;
      next_st.dev_wr = 1'b0;
      next_st.dev_rd = 1'b0;
      next_st.pulse_go = 4'h0;
      // read data is latched in the setup cycle, so the slave never waits
      if (psel_i && !penable_i) begin
         next_st.pslverr = 1'b0;
         next_st.prdata = 32'h0000_0000;
         case (paddr_i)
            `TCC_A_CMD: next_st.prdata = {16'h0000, st.val, 4'h0, st.tgt, st.ch, 1'b0};
            `TCC_A_STAT: begin
               next_st.prdata = {22'h00_0000, pulse_busy, timer_output_pin_i, st.ovf,
                  st.err, busy};
            end
            `TCC_A_PULSE: next_st.prdata = {28'h000_0000, pulse_busy};
            default: next_st.pslverr = 1'b1;
         endcase
      end
      if (wr_acc && paddr_i == `TCC_A_PULSE) begin
         next_st.pulse_go = pwdata_i[3:0] & ~pulse_busy;
      end
      case (st.seq)
         tcc_pkg::S_IDLE: begin
            if (go) begin
               next_st.ch = c;
               next_st.tgt = t;
               next_st.val = v;
               if (cfg_ok(t, v, st.prm[c], st.crc[c], st.toc[c], st.mode[c])) begin
                  case (t)
                     tcc_pkg::T_PRM: next_st.prm[c] = v;
                     tcc_pkg::T_CRC: next_st.crc[c] = v;
                     tcc_pkg::T_TOC: next_st.toc[c] = v & ~8'h0C; // [RULE11]
                     default: next_st.mode[c] = v[3:1];
                  endcase
                  next_st.dev_rd = 1'b1;
                  next_st.dev_addr = addr_of(tcc_pkg::T_TMC, c);
                  next_st.seq = tcc_pkg::S_RD;
               end else begin
                  set_err = 1'b1;
               end
            end
         end
         tcc_pkg::S_RD: next_st.seq = tcc_pkg::S_WAIT;
         tcc_pkg::S_WAIT: begin
            // keep the overflow flag, zero the mode bits to stop the timer
            next_st.saved = dev_rdata_i;
            next_st.ovf[st.ch] = dev_rdata_i[`TCC_TMC_OVF]; // [RULE20]
            next_st.dev_wr = 1'b1;
            next_st.dev_wdata = dev_rdata_i & `TCC_OVF_MASK; // [RULE4]
            next_st.seq = tcc_pkg::S_STOP;
         end
         tcc_pkg::S_STOP: begin
            next_st.dev_wr = 1'b1;
            next_st.dev_addr = addr_of(st.tgt, st.ch);
            if (st.tgt == tcc_pkg::T_TMC) begin
               next_st.dev_wdata = st.val | (st.saved & `TCC_OVF_MASK); // [RULE21]
            end else begin
               next_st.dev_wdata = st.val; // [RULE4]
            end
            next_st.seq = tcc_pkg::S_WR;
         end
         tcc_pkg::S_WR: begin
            if (st.tgt == tcc_pkg::T_TMC) begin
               next_st.seq = tcc_pkg::S_IDLE;
            end else begin
               // restart in the mode the timer had before the stop
               next_st.dev_wr = 1'b1;
               next_st.dev_addr = addr_of(tcc_pkg::T_TMC, st.ch);
               next_st.dev_wdata = st.saved & (`TCC_TMC_MASK | `TCC_OVF_MASK); // [RULE21]
               next_st.seq = tcc_pkg::S_REST;
            end
         end
         tcc_pkg::S_REST: next_st.seq = tcc_pkg::S_IDLE;
         default: next_st.seq = tcc_pkg::S_IDLE;
      endcase
      // a rejection in the clearing cycle still shows
      next_st.err = (st.err && !clr_err) || set_err;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o = st.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = st.pslverr && psel_i && penable_i;
   assign dev_addr_o = st.dev_addr;
   assign dev_wdata_o = st.dev_wdata;
   assign dev_wr_o = st.dev_wr;
   assign dev_rd_o = st.dev_rd;

   // one driver per input pin; width follows the channel's count clock
   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_pin
      tcc_pulse u_pulse (
         .sys_clk_i(sys_clk_i),
         .rst_i(rst_i),
         .start_i(st.pulse_go[gi]),
         .width_i(pulse_width(st.prm[gi / 2][`TCC_PRM_CLK_LSB +: 2])), // [RULE7]
         .pin_o(pin_w[gi]),
         .busy_o(pulse_busy[gi])
      );
   end

   assign first_timer_input_o = {pin_w[2], pin_w[0]};
   assign second_timer_input_o = {pin_w[3], pin_w[1]};

   // checks on what is written to the device
   logic stop_wr;
   logic tmc_wr;
   logic prm_wr;
   logic crc_wr;
   logic toc_wr;
   assign tmc_wr = st.dev_wr && st.dev_addr == addr_of(tcc_pkg::T_TMC, st.ch);
   assign prm_wr = st.dev_wr && st.dev_addr == addr_of(tcc_pkg::T_PRM, st.ch);
   assign crc_wr = st.dev_wr && st.dev_addr == addr_of(tcc_pkg::T_CRC, st.ch);
   assign toc_wr = st.dev_wr && st.dev_addr == addr_of(tcc_pkg::T_TOC, st.ch);
   assign stop_wr = tmc_wr && st.dev_wdata[3:1] == 3'b000;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_stop_then_write;
      stop_wr ##1 st.dev_wr;
   endsequence

   property p_stop_before_cfg;
      (st.dev_wr && !tmc_wr) |-> $past(stop_wr, 1);
   endproperty
   a_stop_before_cfg: assert property (p_stop_before_cfg) // [RULE4]
      else $error("config written while running");

   // only the stop of a sequence has a write behind it; a restore of a halted timer has none
   property p_stop_seq;
      (stop_wr && st.seq == tcc_pkg::S_STOP) |-> s_stop_then_write;
   endproperty
   a_stop_seq: assert property (p_stop_seq) // [RULE4]
      else $error("stop not followed by write");

   property p_mode_after_stop;
      (tmc_wr && st.dev_wdata[3:1] != 3'b000) |-> ($past(stop_wr, 1) || $past(stop_wr, 2));
   endproperty
   a_mode_after_stop: assert property (p_mode_after_stop) // [RULE21]
      else $error("mode set while running");

   property p_no_capture_clear;
      (crc_wr && st.dev_wdata[`TCC_CRC_CAP1]) |-> st.mode[st.ch][2:1] != 2'b11;
   endproperty
   a_no_capture_clear: assert property (p_no_capture_clear) // [RULE5]
      else $error("capture in clear mode");

   property p_set_reset;
      toc_wr |-> !(st.dev_wdata[`TCC_TOC_SET] && st.dev_wdata[`TCC_TOC_RST]);
   endproperty
   a_set_reset: assert property (p_set_reset) // [RULE10]
      else $error("set and reset both written");

   property p_upper_zero;
      toc_wr |-> st.dev_wdata[7:5] == 3'b000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) // [RULE13]
      else $error("upper output bits not zero");

   property p_edge2_legal;
      prm_wr |-> st.dev_wdata[`TCC_PRM_ES1_LSB +: 2] != 2'b10 && st.prm[st.ch] == st.dev_wdata;
   endproperty
   a_edge2_legal: assert property (p_edge2_legal) // [RULE14]
      else $error("second edge field is 10");

   property p_edge1_legal;
      prm_wr |-> st.dev_wdata[`TCC_PRM_ES0_LSB +: 2] != 2'b10;
   endproperty
   a_edge1_legal: assert property (p_edge1_legal) // [RULE15]
      else $error("first edge field is 10");

   property p_ext_no_gate;
      (toc_wr && st.dev_wdata[`TCC_TOC_GATE]) |-> st.prm[st.ch][`TCC_PRM_CLK_LSB +: 2] != 2'b11;
   endproperty
   a_ext_no_gate: assert property (p_ext_no_gate) // [RULE18]
      else $error("output on clock input pin");

   // mode read, one wait for the data, then the stop
   sequence s_read_stop;
      st.dev_rd ##2 stop_wr;
   endsequence

   property p_read_then_stop;
      st.dev_rd |-> s_read_stop;
   endproperty
   a_read_then_stop: assert property (p_read_then_stop) // [RULE4]
      else $error("no stop after mode read");

   property p_restore_after_cfg;
      (st.dev_wr && !tmc_wr) |=> tmc_wr;
   endproperty
   a_restore_after_cfg: assert property (p_restore_after_cfg) // [RULE21]
      else $error("timer not restored after config");

   property p_ext_no_trigger;
      (crc_wr && st.prm[st.ch][`TCC_PRM_CLK_LSB +: 2] == 2'b11) |-> !ti_trig(st.dev_wdata);
   endproperty
   a_ext_no_trigger: assert property (p_ext_no_trigger) // [RULE18]
      else $error("capture on clock input pin");
endmodule : tcc_host
`default_nettype wire

/* File: sim/tcc_dev_model.sv */
// behavioural timer device: control registers, output flip-flop and read port
`timescale 1ns/1ps
`default_nettype none
module tcc_dev_model (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic [1:0] pin_o,
   output logic viol_o
);
   logic [1:0][7:0] tmc;
   logic [1:0][7:0] crc;
   logic [1:0][7:0] toc;
   logic [7:0] prm;
   logic [1:0] ff;
   logic [7:0] rd_val;
   logic ch;
   assign ch = addr_i[3];
   assign pin_o = {toc[1][0] & ff[1], toc[0][0] & ff[0]};
   always_comb begin
      case (addr_i[2:0])
         3'd0: rd_val = tmc[ch];
         3'd1: rd_val = prm;
         3'd2: rd_val = crc[ch];
         default: rd_val = toc[ch];
      endcase
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tmc <= '0;
         crc <= '0;
         toc <= '0;
         prm <= 8'h00;
         ff <= 2'b00;
         rdata_o <= 8'h00;
         viol_o <= 1'b0;
      end else begin
         // a released read port wanders so stale data is never mistaken for valid
         if (rd_i) rdata_o <= rd_val;
         else rdata_o <= ~rdata_o;
         if (wr_i) begin
            if (addr_i[15:4] != 12'hFF6) viol_o <= 1'b1;
            case (addr_i[2:0])
               3'd0: begin
                  if (tmc[ch][3:1] != 3'd0 && wdata_i[3:1] != 3'd0) viol_o <= 1'b1;
                  tmc[ch] <= wdata_i & 8'h0F;
               end
               3'd1: begin
                  if (tmc[0][3:1] != 3'd0) viol_o <= 1'b1;
                  prm <= wdata_i;
               end
               3'd2: begin
                  if (tmc[ch][3:1] != 3'd0) viol_o <= 1'b1;
                  crc[ch] <= wdata_i & 8'h07;
               end
               default: begin
                  if (tmc[ch][3:1] != 3'd0 || wdata_i[3:2] == 2'b11) viol_o <= 1'b1;
                  toc[ch] <= wdata_i & 8'h13;
                  if (wdata_i[3]) ff[ch] <= 1'b1;
                  else if (wdata_i[2]) ff[ch] <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : tcc_dev_model
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the timer capture host controller
`include "tcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, dev_wr, dev_rd, viol, e;
   logic [15:0] dev_addr;
   logic [7:0] dev_wdata, dev_rdata;
   logic [1:0] out_pin, ti_first, ti_second;
   logic [9:0] bad_t [4];
   logic [7:0] oc_t [5];
   logic [4:0] pin_t;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   int hw [2] = '{0, 0};
   int hc [2] = '{0, 0};
   always #2 sys_clk_i = ~sys_clk_i;
   tcc_host DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata),
      .dev_wr_o(dev_wr), .dev_rd_o(dev_rd), .dev_rdata_i(dev_rdata),
      .timer_output_pin_i(out_pin), .first_timer_input_o(ti_first),
      .second_timer_input_o(ti_second));
   tcc_dev_model u_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(dev_addr),
      .wdata_i(dev_wdata), .wr_i(dev_wr), .rd_i(dev_rd), .rdata_o(dev_rdata),
      .pin_o(out_pin), .viol_o(viol));
   // high-phase width of channel 0 input pins, in clock cycles
   always @(posedge sys_clk_i) begin
      for (int j = 0; j < 2; j++) begin
         if ((j == 0 ? ti_first[0] : ti_second[0]) === 1'b1) hc[j]++;
         else if (hc[j] != 0) begin
            hw[j] = hc[j];
            hc[j] = 0;
         end
      end
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one idle edge after release keeps back-to-back calls from double-driving psel
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   // issue one device command and leave the final status word in r
   task automatic go(input logic ch, input logic [1:0] tgt, input logic [7:0] v);
      int n;
      n = 0;
      apb(1'b1, `TCC_A_CMD, {16'h0, v, 4'h0, tgt, ch, 1'b1});
      do begin
         apb(1'b0, `TCC_A_STAT, 32'h0);
         n++;
      end while (r[0] !== 1'b0 && n < 50);
   endtask : go
   initial begin
      bad_t = '{{2'd0, 8'h20}, {2'd0, 8'h80}, {2'd2, 8'h0C}, {2'd1, 8'h01}};
      oc_t = '{8'h09, 8'h01, 8'h05, 8'h09, 8'h08};
      pin_t = 5'b01011;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      apb(1'b0, `TCC_A_STAT, 32'h0);
      chk(r, 32'h0);
      chk({ti_first, ti_second, out_pin}, 32'h0);
      $display("test reset done");
      go(1'b0, 2'd3, 8'h04);
      chk(u_dev.tmc[0], 32'h04);
      go(1'b0, 2'd0, 8'h51);
      chk(u_dev.prm, 32'h51);
      chk(u_dev.tmc[0], 32'h04);
      $display("test prescale done");
      for (int i = 0; i < 5; i++) begin
         go(1'b0, 2'd2, oc_t[i]);
         chk(u_dev.toc[0], oc_t[i] & 8'h13);
         chk(out_pin[0], pin_t[i]);
         chk(r[4], pin_t[i]);
      end
      $display("test output control done");
      go(1'b0, 2'd3, 8'h0C);
      for (int i = 0; i < 4; i++) begin
         go(1'b0, bad_t[i][9:8], bad_t[i][7:0]);
         chk(r[1], 32'h1);
         apb(1'b1, `TCC_A_STAT, 32'h2);
      end
      chk({u_dev.prm, u_dev.toc[0], u_dev.crc[0]}, 32'h00510000);
      go(1'b0, 2'd3, 8'h04);
      $display("test refusals done");
      for (int i = 0; i < 8; i++) begin
         go(1'b1, 2'd1, i[7:0]);
         chk(r[1], 32'h0);
         chk(u_dev.crc[1], i);
      end
      $display("test capture modes done");
      for (int i = 0; i < 3; i++) begin
         go(1'b0, 2'd0, 8'h50 | i[7:0]);
         apb(1'b1, `TCC_A_PULSE, (i == 1) ? 32'h2 : 32'h1);
         for (int n = 0; n < 1500; n++) begin
            apb(1'b0, `TCC_A_STAT, 32'h0);
            if (r[9:6] === 4'h0) break;
         end
         chk(hw[i == 1], `TCC_FX_CYC * ((i == 0) ? 2 : (i == 1) ? 8 : 64) + 1);
      end
      $display("test pulse widths done");
      apb(1'b0, `TCC_A_CMD, 32'h0);
      chk(r, 32'h5200);
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      chk(e, 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk(r, 32'h0);
      chk(viol, 32'h0);
      $display("test readback done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
